// ==== hdl/erm_pkg.sv ====
// package for the external register access map
package erm_pkg;
    // external register offsets
    localparam logic [2:0] ADDR_DATA_LOW   = 3'h0;
    localparam logic [2:0] ADDR_DATA_MID   = 3'h1;
    localparam logic [2:0] ADDR_DATA_HIGH  = 3'h2;
    localparam logic [2:0] ADDR_SLEEP      = 3'h3;
    localparam logic [2:0] ADDR_PIN_TRIG   = 3'h4;
    localparam logic [2:0] ADDR_SOFT_TRIG  = 3'h5;
    localparam logic [2:0] ADDR_POINTER    = 3'h6;
    localparam logic [2:0] ADDR_ACCESS     = 3'h7;
    // access_selection_control fields
    localparam int ACC_AUTOINC_BIT   = 7;
    localparam int ACC_BCAST_BIT     = 6;
    localparam int ACC_INSTR_LSB     = 2;
    localparam int ACC_CHAN_LSB      = 0;
    // software_trigger_control fields
    localparam int SOFT_START_BIT    = 4;
    localparam int SOFT_HOP_BIT      = 5;
    localparam int SOFT_TEST_BIT     = 6;
    localparam int SOFT_NOISE_BIT    = 7;
    // pin_trigger_control fields
    localparam int PIN_START_BIT     = 4;
    localparam int PIN_HOP_BIT       = 5;
    localparam int PIN_FIRST_BIT     = 6;
    // channel_sleep_control fields
    localparam int SLEEP_PAGE_BIT    = 5;
    // broadcast instruction codes
    localparam logic [3:0] INSTR_ALL        = 4'h0;
    localparam logic [3:0] INSTR_CH012      = 4'h1;
    localparam logic [3:0] INSTR_CH123      = 4'h2;
    localparam logic [3:0] INSTR_ALL_CHIPS  = 4'h4;
    localparam logic [2:0] INSTR_LSB1_PFX   = 3'h4;
    localparam logic [1:0] INSTR_LSB2_PFX   = 2'h3;
    // reset values, channel masks and pointer step
    localparam logic [7:0] RESET_BYTE      = 8'h00;
    localparam logic [3:0] RESET_NIBBLE    = 4'h0;
    localparam logic [3:0] CHAN_MASK_ALL   = 4'hF;
    localparam logic [3:0] CHAN_MASK_012   = 4'h7;
    localparam logic [3:0] CHAN_MASK_123   = 4'hE;
    localparam logic [3:0] CHAN_MASK_NONE  = 4'h0;
    localparam logic [3:0] CHAN_ONE        = 4'h1;
    localparam logic [7:0] POINTER_STEP    = 8'h01;
    // internal page select
    localparam logic       PAGE_CHANNEL    = 1'b0;
    localparam logic       PAGE_OUTPUT     = 1'b1;
endpackage : erm_pkg

// ==== hdl/erm_external_register_access_map.sv ====
// external register access map of the multi-channel receiver control interface
// ==================================================================
// Behaviour
// - all internal page access goes only through these eight registers
// - one map shared by parallel and serial port, same functions
// - autoincrement bit advances pointer after each low data access
// - broadcast clear: instruction must equal identity pins to accept
// - broadcast codes 0000 all, 0001 channels 0-2, 0010 channels 1-3
// - 0100 all chips, 100x and 11yy match identity LSBs, channel bits select
// - no valid readback while broadcast set; host clears it first
// - channel bits select one channel, ignored for multi-channel instructions
// - pointer register holds internal address for data accesses
// - software trigger bits 3-0 select pulse recipient channels
// - start bit gives one-shot start pulse, copies to per-channel pin config
// - hop bit gives one-shot hop pulse, copies to per-channel pin config
// - test override bit feeds internal test signals to all oscillators
// - noise select picks noise generator, else negative full scale
// - pin trigger register holds enables, start, hop, first-only routing
// - sleep register holds channel sleep bits and output page select
// - 20-bit data word assembled from three data registers
// - low data register write triggers access; read of it starts read
// - high sleep bit sleeps that channel
// - page select steers pointer to output port page
`timescale 1ns/1ns
module erm_external_register_access_map
    import erm_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // host port, shared by parallel and serial front ends
    input  wire logic        hostWrite,
    input  wire logic        hostRead,
    input  wire logic [2:0]  hostAddr,
    input  wire logic [7:0]  hostWrData,
    output logic      [7:0]  hostRdData,
    output logic             hostRdDrive,
    // chip identity pins
    input  wire logic [3:0]  chipIdentityPins,
    // internal access bus
    output logic             intWrite,
    output logic             intRead,
    output logic      [3:0]  intChanSel,
    output logic             intPage,
    output logic      [7:0]  intAddr,
    output logic      [19:0] intWrData,
    input  wire logic [19:0] intRdData,
    // synchronisation and test controls
    output logic      [3:0]  startPulse,
    output logic      [3:0]  hopPulse,
    output logic      [3:0]  pinCfgLoad,
    output logic      [3:0]  pinSyncEnable,
    output logic             pinStartRoute,
    output logic             pinHopRoute,
    output logic             pinFirstOnly,
    output logic      [3:0]  softTrigSelect,
    output logic             softStartCopy,
    output logic             softHopCopy,
    output logic             testInputOverride,
    output logic             noiseSourceSelect,
    output logic      [3:0]  channelSleep
);
    import erm_pkg::*;

    typedef struct packed {
        // host-visible registers, registered outputs and read pending flag
        logic [7:0]  accessCtrl;
        logic [7:0]  pointer;
        logic [7:0]  dataLow;
        logic [7:0]  dataMid;
        logic [3:0]  dataHigh;
        logic [7:0]  rdData;
        logic        rdDrive;
        logic        intWrite;
        logic        intRead;
        logic [3:0]  chanSel;
        logic        page;
        logic [7:0]  intAddr;
        logic [19:0] intWrData;
        logic [3:0]  startPulse;
        logic [3:0]  hopPulse;
        logic [3:0]  pinCfgLoad;
        logic [3:0]  pinEnable;
        logic        pinStart;
        logic        pinHop;
        logic        pinFirst;
        logic [3:0]  softSelect;
        logic        softStart;
        logic        softHop;
        logic        testOverride;
        logic        noiseSelect;
        logic [3:0]  sleep;
        logic        rdPending;
        // identity pin synchroniser
        logic [3:0]  idSync1;
        logic [3:0]  idSync2;
        logic [3:0]  idSync3;
        logic [3:0]  idStable;
    } erm_state_s;

    erm_state_s st;
    erm_state_s next_st;

    logic [3:0] instr;
    logic       bcast;
    logic [1:0] chanBits;
    logic [3:0] decodedMask;
    logic [3:0] oneChan;

    // ==================================================================
    // instruction decode
    always_comb
    begin
        instr    = st.accessCtrl[ACC_INSTR_LSB +: 4];
        bcast    = st.accessCtrl[ACC_BCAST_BIT];
        chanBits = st.accessCtrl[ACC_CHAN_LSB +: 2];
        oneChan  = CHAN_ONE << chanBits;
        // a miss leaves the mask empty, which refuses the access
        decodedMask = CHAN_MASK_NONE;
        if (!bcast)
        begin
            if (instr == st.idStable)
                decodedMask = oneChan;
        end
        else if (instr == INSTR_ALL)
            decodedMask = CHAN_MASK_ALL;
        else if (instr == INSTR_CH012)
            decodedMask = CHAN_MASK_012;
        else if (instr == INSTR_CH123)
            decodedMask = CHAN_MASK_123;
        else if (instr == INSTR_ALL_CHIPS)
            decodedMask = oneChan;
        else if (instr[3:1] == INSTR_LSB1_PFX && instr[0] == st.idStable[0])
            decodedMask = oneChan;
        else if (instr[3:2] == INSTR_LSB2_PFX && instr[1:0] == st.idStable[1:0])
            decodedMask = oneChan;
    end

    // ==================================================================
    // register file and internal access sequencing
    always_comb
    begin
        next_st            = st;
        next_st.intWrite   = 1'b0;
        next_st.intRead    = 1'b0;
        // pulses last one cycle unless a write sets them again
        next_st.startPulse = CHAN_MASK_NONE;
        next_st.hopPulse   = CHAN_MASK_NONE;
        next_st.pinCfgLoad = CHAN_MASK_NONE;
        next_st.rdPending  = 1'b0;

        // identity pins pass three stages; a new value counts once stages two and three agree
        next_st.idSync1 = chipIdentityPins;
        next_st.idSync2 = st.idSync1;
        next_st.idSync3 = st.idSync2;
        if (st.idSync2 == st.idSync3)
            next_st.idStable = st.idSync3;
        // read data captured one cycle after an internal read
        if (st.rdPending)
        begin
            next_st.dataLow  = intRdData[7:0];
            next_st.dataMid  = intRdData[15:8];
            next_st.dataHigh = intRdData[19:16];
            next_st.rdData   = intRdData[7:0];
        end
        if (hostWrite)
        begin
            case (hostAddr)
                ADDR_ACCESS:    next_st.accessCtrl = hostWrData;
                ADDR_POINTER:   next_st.pointer    = hostWrData;
                ADDR_SOFT_TRIG:
                begin
                    next_st.softSelect   = hostWrData[3:0];
                    next_st.softStart    = hostWrData[SOFT_START_BIT];
                    next_st.softHop      = hostWrData[SOFT_HOP_BIT];
                    next_st.testOverride = hostWrData[SOFT_TEST_BIT];
                    next_st.noiseSelect  = hostWrData[SOFT_NOISE_BIT];
                    if (hostWrData[SOFT_START_BIT])
                        next_st.startPulse = hostWrData[3:0];
                    if (hostWrData[SOFT_HOP_BIT])
                        next_st.hopPulse = hostWrData[3:0];
                    next_st.pinCfgLoad = CHAN_MASK_ALL;
                end
                ADDR_PIN_TRIG:
                begin
                    next_st.pinEnable  = hostWrData[3:0];
                    next_st.pinStart   = hostWrData[PIN_START_BIT];
                    next_st.pinHop     = hostWrData[PIN_HOP_BIT];
                    next_st.pinFirst   = hostWrData[PIN_FIRST_BIT];
                    next_st.pinCfgLoad = CHAN_MASK_ALL;
                end
                ADDR_SLEEP:
                begin
                    next_st.sleep = hostWrData[3:0];
                    next_st.page  = hostWrData[SLEEP_PAGE_BIT];
                end
                ADDR_DATA_HIGH:
                begin
                    if (decodedMask != CHAN_MASK_NONE)
                        next_st.dataHigh = hostWrData[3:0];
                end
                ADDR_DATA_MID:
                begin
                    if (decodedMask != CHAN_MASK_NONE)
                        next_st.dataMid = hostWrData;
                end
                ADDR_DATA_LOW:
                begin
                    if (decodedMask != CHAN_MASK_NONE)
                    begin
                        next_st.dataLow   = hostWrData;
                        next_st.intWrite  = 1'b1;
                        next_st.chanSel   = decodedMask;
                        next_st.intAddr   = st.pointer;
                        next_st.intWrData = {st.dataHigh, st.dataMid, hostWrData};
                        if (st.accessCtrl[ACC_AUTOINC_BIT])
                            next_st.pointer = st.pointer + POINTER_STEP;
                    end
                end
                default: ;
            endcase
        end
        else if (hostRead)
        begin
            // nothing is driven under broadcast, the internal bus may be contended
            next_st.rdDrive = 1'b0;
            case (hostAddr)
                ADDR_ACCESS:
                begin
                    next_st.rdData  = st.accessCtrl;
                    next_st.rdDrive = !bcast;
                end
                ADDR_POINTER:
                begin
                    next_st.rdData  = st.pointer;
                    next_st.rdDrive = !bcast;
                end
                ADDR_DATA_HIGH:
                begin
                    next_st.rdData  = {RESET_NIBBLE, st.dataHigh};
                    next_st.rdDrive = !bcast && decodedMask != CHAN_MASK_NONE;
                end
                ADDR_DATA_MID:
                begin
                    next_st.rdData  = st.dataMid;
                    next_st.rdDrive = !bcast && decodedMask != CHAN_MASK_NONE;
                end
                ADDR_DATA_LOW:
                begin
                    if (!bcast && decodedMask != CHAN_MASK_NONE)
                    begin
                        next_st.intRead   = 1'b1;
                        next_st.rdPending = 1'b1;
                        next_st.rdDrive   = 1'b1;
                        next_st.chanSel   = decodedMask;
                        next_st.intAddr   = st.pointer;
                        if (st.accessCtrl[ACC_AUTOINC_BIT])
                            next_st.pointer = st.pointer + POINTER_STEP;
                    end
                end
                // write-only registers read as zero and are not driven
                default: next_st.rdData = RESET_BYTE;
            endcase
        end
    end

    // ==================================================================
    // state register
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    // ==================================================================
    // outputs
    assign hostRdData        = st.rdData;
    assign hostRdDrive       = st.rdDrive;
    assign intWrite          = st.intWrite;
    assign intRead           = st.intRead;
    assign intChanSel        = st.chanSel;
    assign intPage           = st.page;
    assign intAddr           = st.intAddr;
    assign intWrData         = st.intWrData;
    assign startPulse        = st.startPulse;
    assign hopPulse          = st.hopPulse;
    assign pinCfgLoad        = st.pinCfgLoad;
    assign pinSyncEnable     = st.pinEnable;
    assign pinStartRoute     = st.pinStart;
    assign pinHopRoute       = st.pinHop;
    assign pinFirstOnly      = st.pinFirst;
    assign softTrigSelect    = st.softSelect;
    assign softStartCopy     = st.softStart;
    assign softHopCopy       = st.softHop;
    assign testInputOverride = st.testOverride;
    assign noiseSourceSelect = st.noiseSelect;
    assign channelSleep      = st.sleep;
endmodule : erm_external_register_access_map

// ==== verification/erm_page_model.sv ====
// behavioural model of the internal channel page memory
`timescale 1ns/1ns
module erm_page_model
(
    // clock
    input  wire logic        core_clk,
    // internal access bus
    input  wire logic        intWrite,
    input  wire logic        intRead,
    input  wire logic [7:0]  intAddr,
    input  wire logic [19:0] intWrData,
    output logic      [19:0] intRdData
);
    logic [19:0] pageMem [16];
    logic [19:0] lastWord = 20'h00000;
    // store whole words, answer while the read strobe stands
    always_ff @(posedge core_clk)
    begin
        if (intWrite)
            pageMem[intAddr[3:0]] <= intWrData;
        if (intRead)
            lastWord <= pageMem[intAddr[3:0]];
    end
    // released bus shows the inverse of the last word
    assign intRdData = intRead ? pageMem[intAddr[3:0]] : ~lastWord;
endmodule : erm_page_model

// ==== verification/erm_map_chk.sv ====
// port checker for the external register access map
`timescale 1ns/1ns
module erm_map_chk
    import erm_pkg::*;
(
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst_n,
    // host port and pins
    input wire logic       hostWrite,
    input wire logic       hostRead,
    input wire logic [2:0] hostAddr,
    input wire logic [7:0] hostWrData,
    input wire logic       hostRdDrive,
    input wire logic [3:0] chipIdentityPins,
    // outputs watched
    input wire logic       intWrite,
    input wire logic       intRead,
    input wire logic [3:0] intChanSel,
    input wire logic [3:0] startPulse,
    input wire logic [3:0] hopPulse,
    input wire logic [3:0] pinCfgLoad,
    input wire logic [3:0] channelSleep
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] access_selection_control;
    logic       lastWr;
    logic [2:0] lastAddr;
    logic [7:0] lastData;
    logic       dataWr;
    logic       idHit;
    // shadow of the access control byte and of the last host cycle
    always_ff @(posedge core_clk)
    begin
        access_selection_control <= !rst_n ? RESET_BYTE : (hostWrite && hostAddr == ADDR_ACCESS) ? hostWrData : access_selection_control;
        lastWr <= hostWrite;
        lastAddr <= hostAddr;
        lastData <= hostWrData;
    end
    assign dataWr = hostWrite && hostAddr == ADDR_DATA_LOW;
    assign idHit = !access_selection_control[6] && access_selection_control[5:2] == chipIdentityPins;
    // ==================================================================
    // assertions
    wr_pulse_a: assert property (intWrite && !dataWr |=> !intWrite)
        else $error("internal write longer than one cycle");
    id_miss_a: assert property (dataWr && !access_selection_control[6] && !idHit |=> !intWrite)
        else $error("write taken without identity match");
    id_hit_a: assert property (dataWr && idHit |=> intWrite && intChanSel == (CHAN_ONE << access_selection_control[1:0]))
        else $error("matched write has wrong channel");
    bc_all_a: assert property (dataWr && access_selection_control[6] && access_selection_control[5:2] == INSTR_ALL |=> intWrite && intChanSel == CHAN_MASK_ALL)
        else $error("broadcast all not decoded");
    bc_read_a: assert property (hostRead && !hostWrite && access_selection_control[6] |=> !hostRdDrive)
        else $error("read answered under broadcast");
    rd_start_a: assert property (hostRead && !hostWrite && hostAddr == ADDR_DATA_LOW && idHit |=> intRead && hostRdDrive)
        else $error("low data read did not start access");
    start_sel_a: assert property (startPulse != 4'h0 |-> lastWr && lastAddr == ADDR_SOFT_TRIG && lastData[4] && startPulse == lastData[3:0])
        else $error("start pulse without cause");
    hop_sel_a: assert property (hopPulse != 4'h0 |-> lastWr && lastAddr == ADDR_SOFT_TRIG && lastData[5] && hopPulse == lastData[3:0])
        else $error("hop pulse without cause");
    cfg_load_a: assert property (pinCfgLoad != 4'h0 |-> pinCfgLoad == CHAN_MASK_ALL && lastWr && lastAddr[2:1] == 2'h2)
        else $error("copy load without cause");
    sleep_set_a: assert property (hostWrite && hostAddr == ADDR_SLEEP |=> channelSleep == lastData[3:0])
        else $error("sleep bits not taken");
    cover property (intWrite && intChanSel == CHAN_MASK_ALL);
    cover property (startPulse != 4'h0);
    cover property (hostRead && access_selection_control[6]);
endmodule : erm_map_chk
bind erm_external_register_access_map erm_map_chk i_chk (.core_clk, .rst_n, .hostWrite, .hostRead, .hostAddr,
    .hostWrData, .hostRdDrive, .chipIdentityPins, .intWrite, .intRead, .intChanSel, .startPulse, .hopPulse,
    .pinCfgLoad, .channelSleep);

// ==== verification/erm_external_register_access_map_test.sv ====
// self-checking bench for the external register access map
`timescale 1ns/1ns
module erm_external_register_access_map_test;
    import erm_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b0, hostWrite = 1'b0, hostRead = 1'b0, hostRdDrive, intWrite, intRead;
    logic [2:0] hostAddr = 3'h0;
    logic [7:0] hostWrData = 8'h00, hostRdData, intAddr, rdByte;
    logic [3:0] chipIdentityPins = 4'h5, intChanSel, startPulse, hopPulse, pinCfgLoad, pinSyncEnable;
    logic [3:0] softTrigSelect, channelSleep;
    logic intPage, pinStartRoute, pinHopRoute, pinFirstOnly, softStartCopy, softHopCopy;
    logic testInputOverride, noiseSourceSelect, rdDrv;
    logic [19:0] intWrData, intRdData;
    logic [33:0] sSnap;
    logic [11:0] sPulse;
    int failures = 0, total_checks = 0;
    logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h9, 4'hC, 4'hD, 4'hE, 4'hF, 4'h3};
    logic [3:0] masks [11] = '{4'hF, 4'h7, 4'hE, 4'h2, 4'h0, 4'h2, 4'h0, 4'h2, 4'h0, 4'h0, 4'h0};
    always #5 core_clk = ~core_clk;
    erm_external_register_access_map i_dut (.core_clk, .rst_n, .hostWrite, .hostRead, .hostAddr, .hostWrData,
        .hostRdData, .hostRdDrive, .chipIdentityPins, .intWrite, .intRead, .intChanSel, .intPage, .intAddr,
        .intWrData, .intRdData, .startPulse, .hopPulse, .pinCfgLoad, .pinSyncEnable, .pinStartRoute,
        .pinHopRoute, .pinFirstOnly, .softTrigSelect, .softStartCopy, .softHopCopy, .testInputOverride,
        .noiseSourceSelect, .channelSleep);
    erm_page_model i_model (.core_clk, .intWrite, .intRead, .intAddr, .intWrData, .intRdData);
    // ==================================================================
    // shared tasks
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge core_clk);
        hostWrite = 1'b1;
        hostAddr = a;
        hostWrData = d;
        @(negedge core_clk);
        hostWrite = 1'b0;
        sSnap = {intWrite, intChanSel, intPage, intAddr, intWrData};
        sPulse = {startPulse, hopPulse, pinCfgLoad};
    endtask : wr
    task automatic rd(input logic [2:0] a);
        @(negedge core_clk);
        hostRead = 1'b1;
        hostAddr = a;
        @(negedge core_clk);
        hostRead = 1'b0;
        if (a == ADDR_DATA_LOW)
            @(negedge core_clk);
        rdByte = hostRdData;
        rdDrv = hostRdDrive;
    endtask : rd
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (5000) @(posedge core_clk);
        failures++;
        test_done();
    end
    // ==================================================================
    // tests
    initial
    begin
        repeat (10) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        chk({intWrite, intRead, hostRdDrive, startPulse, channelSleep, intWrData}, 34'h0);
        $display("test reset done");
        wr(ADDR_ACCESS, 8'h96);
        wr(ADDR_POINTER, 8'h10);
        wr(ADDR_DATA_HIGH, 8'hF3);
        wr(ADDR_DATA_MID, 8'hAB);
        wr(ADDR_DATA_LOW, 8'hCD);
        chk(sSnap, {1'b1, 4'h4, 1'b0, 8'h10, 20'h3ABCD});
        rd(ADDR_POINTER);
        chk(rdByte, 8'h11);
        wr(ADDR_POINTER, 8'h10);
        rd(ADDR_DATA_LOW);
        chk({rdDrv, rdByte}, 9'h1CD);
        rd(ADDR_DATA_MID);
        chk(rdByte, 8'hAB);
        rd(ADDR_DATA_HIGH);
        chk(rdByte, 8'h03);
        $display("test matched access done");
        wr(ADDR_ACCESS, 8'h18);
        wr(ADDR_DATA_LOW, 8'h11);
        chk(sSnap[33], 1'b0);
        rd(ADDR_DATA_LOW);
        chk(rdDrv, 1'b0);
        wr(ADDR_DATA_MID, 8'h55);
        wr(ADDR_ACCESS, 8'h96);
        rd(ADDR_ACCESS);
        chk({rdDrv, rdByte}, 9'h196);
        rd(ADDR_DATA_MID);
        chk(rdByte, 8'hAB);
        $display("test identity miss done");
        for (int i = 0; i < 11; i++)
        begin
            wr(ADDR_ACCESS, {2'b01, codes[i], 2'b01});
            wr(ADDR_DATA_LOW, 8'(i));
            chk({sSnap[33], sSnap[33] ? sSnap[32:29] : 4'h0}, {|masks[i], masks[i]});
        end
        rd(ADDR_POINTER);
        chk(rdDrv, 1'b0);
        $display("test broadcast done");
        wr(ADDR_SOFT_TRIG, 8'hF5);
        chk(sPulse, 12'h55F);
        chk({softTrigSelect, softStartCopy, softHopCopy, testInputOverride, noiseSourceSelect}, 8'h5F);
        @(negedge core_clk);
        chk({startPulse, hopPulse, pinCfgLoad}, 12'h000);
        wr(ADDR_SOFT_TRIG, 8'h1A);
        chk(sPulse, 12'hA0F);
        chk({softTrigSelect, softStartCopy, softHopCopy, testInputOverride, noiseSourceSelect}, 8'hA8);
        $display("test soft trigger done");
        wr(ADDR_PIN_TRIG, 8'h5A);
        chk(sPulse, 12'h00F);
        chk({pinSyncEnable, pinStartRoute, pinHopRoute, pinFirstOnly}, 7'h55);
        wr(ADDR_ACCESS, 8'h14);
        rd(ADDR_PIN_TRIG);
        chk({rdDrv, rdByte}, 9'h000);
        wr(ADDR_SLEEP, 8'h29);
        chk(channelSleep, 4'h9);
        wr(ADDR_DATA_LOW, 8'h00);
        chk(sSnap[33:28], 6'h23);
        $display("test pin sleep page done");
        test_done();
    end
endmodule : erm_external_register_access_map_test
